/* design/dhg_decode.sv */
// register bank and cycle steering for the dram hole and graphics memory decode
// Operation
// - enabled hole sends host cycles to hub
// - enabled hole drops hub interface cycles there
// - hole dram is never remapped elsewhere
// - hole enable bit 7, reset off, 15-16MB
// - graphics mode picks off, on with no memory (01), 512KB or 1MB
// - mode 00 hides graphics config, no memory
// - graphics off gates its clocks and functions
// - graphics off forwards vga range to hub
// - graphics on serves non-smm vga, modes 10 and 11 reserve memory
// - lock bit freezes graphics mode field
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
module dhg_decode (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [31:0] mem_top,
    input wire logic host_req,
    input wire logic [31:0] host_addr,
    input wire logic host_smm,
    output logic host_ack,
    output dhg_pkg::dhg_route_t host_route,
    output logic [31:0] host_dram_addr,
    input wire logic hub_req,
    input wire logic [31:0] hub_addr,
    output logic hub_done,
    output logic hub_accept,
    output logic gfx_enable,
    output logic gfx_cfg_visible,
    output logic gfx_clk_en,
    output logic [31:0] gfx_stolen_base
);
    logic hole_en_q;
    logic hole_en_d;
    logic [1:0] gmode_q;
    logic [1:0] gmode_d;
    logic lock_q;
    logic lock_d;
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic addr_phase;
    logic [31:0] rd_word;
    logic [31:0] reserve;
    logic [31:0] stolen;
    dhg_pkg::dhg_route_t host_route_c;
    dhg_pkg::dhg_route_t hub_route_c;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic hresp_q;
    logic host_ack_q;
    dhg_pkg::dhg_route_t host_route_q;
    logic [31:0] host_dram_addr_q;
    logic hub_done_q;
    logic hub_accept_q;
    logic gfx_enable_q;
    logic gfx_cfg_visible_q;
    logic gfx_clk_en_q;
    logic [31:0] gfx_stolen_base_q;

    dhg_cfg_if cfg ();

    // bus address phase and data phase tracking
    assign addr_phase = hsel && hready && (htrans == dhg_pkg::HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end
        else
        begin
            wr_pend_q <= addr_phase && hwrite;
            if (addr_phase)
                wr_addr_q <= {haddr[11:2], 2'h0};
        end
    end

    // register next values from the write in its data phase
    always_comb
    begin
        hole_en_d = hole_en_q;
        gmode_d = gmode_q;
        lock_d = lock_q;
        if (wr_pend_q && (wr_addr_q == dhg_pkg::HOLE_CTRL_OFS))
            hole_en_d = hwdata[dhg_pkg::HOLE_EN_BIT];
        if (wr_pend_q && (wr_addr_q == dhg_pkg::SYSMGMT_CTRL_OFS))
        begin
            if (!lock_q)
                gmode_d = hwdata[dhg_pkg::GMODE_LSB +: 2];
            lock_d = lock_q | hwdata[dhg_pkg::LOCK_BIT];
        end
    end

    // hole control register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hole_en_q <= dhg_pkg::HOLE_CTRL_RST[dhg_pkg::HOLE_EN_BIT];
        else
            hole_en_q <= hole_en_d;
    end

    // graphics mode and lock
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gmode_q <= dhg_pkg::SYSMGMT_CTRL_RST[dhg_pkg::GMODE_LSB +: 2];
            lock_q <= dhg_pkg::SYSMGMT_CTRL_RST[dhg_pkg::LOCK_BIT];
        end
        else
        begin
            gmode_q <= gmode_d;
            lock_q <= lock_d;
        end
    end

    // read mux sees this cycle's write so back to back access is coherent
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (haddr[11:0] == dhg_pkg::HOLE_CTRL_OFS)
            rd_word[dhg_pkg::HOLE_EN_BIT] = hole_en_d;
        else if (haddr[11:0] == dhg_pkg::SYSMGMT_CTRL_OFS)
        begin
            rd_word[dhg_pkg::GMODE_LSB +: 2] = gmode_d;
            rd_word[dhg_pkg::LOCK_BIT] = lock_d;
        end
    end

    // bus answer, zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_q <= 1'b1;
            hresp_q <= dhg_pkg::HRESP_OKAY;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            hreadyout_q <= 1'b1;
            hresp_q <= dhg_pkg::HRESP_OKAY;
            if (addr_phase && !hwrite)
                hrdata_q <= rd_word;
        end
    end

    // graphics memory reservation below top of dram
    always_comb
    begin
        unique case (gmode_q)
            dhg_pkg::GMODE_512K: reserve = dhg_pkg::RSV_512K;
            dhg_pkg::GMODE_1M: reserve = dhg_pkg::RSV_1M;
            dhg_pkg::GMODE_RSVD: reserve = dhg_pkg::RSV_NONE;
            dhg_pkg::GMODE_OFF: reserve = dhg_pkg::RSV_NONE;
        endcase
    end

    assign stolen = mem_top - reserve;
    assign cfg.hole_en = hole_en_q;
    assign cfg.gfx_en = (gmode_q != dhg_pkg::GMODE_OFF);
    assign cfg.stolen_base = stolen;
    assign cfg.mem_top = mem_top;

    dhg_router u_host_rt (
        .cfg(cfg),
        .addr(host_addr),
        .smm(host_smm),
        .route(host_route_c)
    );

    // hub interface cycles carry no smm qualifier
    dhg_router u_hub_rt (
        .cfg(cfg),
        .addr(hub_addr),
        .smm(1'b0),
        .route(hub_route_c)
    );

    // host cycle result, dram address passed through untouched
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            host_ack_q <= 1'b0;
            host_route_q <= dhg_pkg::RT_HUB;
            host_dram_addr_q <= 32'h0000_0000;
        end
        else
        begin
            host_ack_q <= host_req;
            if (host_req)
            begin
                host_route_q <= host_route_c;
                host_dram_addr_q <= host_addr;
            end
        end
    end

    // hub interface cycle claim, hub-bound decodes are ignored
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hub_done_q <= 1'b0;
            hub_accept_q <= 1'b0;
        end
        else
        begin
            hub_done_q <= hub_req;
            hub_accept_q <= hub_req && (hub_route_c != dhg_pkg::RT_HUB);
        end
    end

    // graphics device enables
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gfx_enable_q <= 1'b0;
            gfx_cfg_visible_q <= 1'b0;
            gfx_clk_en_q <= 1'b0;
            gfx_stolen_base_q <= 32'h0000_0000;
        end
        else
        begin
            gfx_enable_q <= cfg.gfx_en;
            gfx_cfg_visible_q <= cfg.gfx_en;
            gfx_clk_en_q <= cfg.gfx_en;
            gfx_stolen_base_q <= stolen;
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = hresp_q;
    assign host_ack = host_ack_q;
    assign host_route = host_route_q;
    assign host_dram_addr = host_dram_addr_q;
    assign hub_done = hub_done_q;
    assign hub_accept = hub_accept_q;
    assign gfx_enable = gfx_enable_q;
    assign gfx_cfg_visible = gfx_cfg_visible_q;
    assign gfx_clk_en = gfx_clk_en_q;
    assign gfx_stolen_base = gfx_stolen_base_q;

    // checks
    logic host_in_hole;
    logic host_in_vga;
    logic hub_in_hole;
    assign host_in_hole = (host_addr >= dhg_pkg::HOLE_BASE) && (host_addr < dhg_pkg::HOLE_LIMIT);
    assign host_in_vga = (host_addr >= dhg_pkg::VGA_BASE) && (host_addr < dhg_pkg::VGA_LIMIT);
    assign hub_in_hole = (hub_addr >= dhg_pkg::HOLE_BASE) && (hub_addr < dhg_pkg::HOLE_LIMIT);

    property p_hole_host;
        @(posedge hclk) disable iff (!hresetn)
        host_req && hole_en_q && host_in_hole |=> host_ack && (host_route == dhg_pkg::RT_HUB);
    endproperty
    a_hole_host: assert property (p_hole_host) else $error("hole cycle not sent to hub");

    property p_hole_hub;
        @(posedge hclk) disable iff (!hresetn)
        hub_req && hole_en_q && hub_in_hole |=> hub_done && !hub_accept;
    endproperty
    a_hole_hub: assert property (p_hole_hub) else $error("hub cycle in hole claimed");

    property p_no_remap;
        @(posedge hclk) disable iff (!hresetn)
        host_req ##1 host_ack |-> host_dram_addr == $past(host_addr);
    endproperty
    a_no_remap: assert property (p_no_remap) else $error("dram address altered");

    property p_hole_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_q && (wr_addr_q == dhg_pkg::HOLE_CTRL_OFS)
            |=> hole_en_q == $past(hwdata[dhg_pkg::HOLE_EN_BIT]);
    endproperty
    a_hole_write: assert property (p_hole_write) else $error("hole enable not written");

    property p_reserve;
        @(posedge hclk) disable iff (!hresetn)
        gmode_q == dhg_pkg::GMODE_1M
            |=> gfx_stolen_base == $past(mem_top) - dhg_pkg::RSV_1M;
    endproperty
    a_reserve: assert property (p_reserve) else $error("1MB reservation wrong");

    property p_gfx_hidden;
        @(posedge hclk) disable iff (!hresetn)
        (gmode_q == dhg_pkg::GMODE_OFF) [*2]
            |=> !gfx_cfg_visible && gfx_stolen_base == $past(mem_top);
    endproperty
    a_gfx_hidden: assert property (p_gfx_hidden) else $error("disabled graphics visible");

    property p_gfx_clk;
        @(posedge hclk) disable iff (!hresetn)
        $changed(gmode_q) && gmode_q == dhg_pkg::GMODE_OFF |=> !gfx_clk_en && !gfx_enable;
    endproperty
    a_gfx_clk: assert property (p_gfx_clk) else $error("graphics clock left on");

    property p_vga_off;
        @(posedge hclk) disable iff (!hresetn)
        host_req && host_in_vga && gmode_q == dhg_pkg::GMODE_OFF
            |=> host_route == dhg_pkg::RT_HUB;
    endproperty
    a_vga_off: assert property (p_vga_off) else $error("vga not forwarded");

    property p_vga_on;
        @(posedge hclk) disable iff (!hresetn)
        host_req && host_in_vga && !host_smm && gmode_q != dhg_pkg::GMODE_OFF
            |=> host_route == dhg_pkg::RT_GFX;
    endproperty
    a_vga_on: assert property (p_vga_on) else $error("vga not served by graphics");

    property p_lock;
        @(posedge hclk) disable iff (!hresetn)
        lock_q && wr_pend_q && (wr_addr_q == dhg_pkg::SYSMGMT_CTRL_OFS) |=> $stable(gmode_q);
    endproperty
    a_lock: assert property (p_lock) else $error("locked mode field written");

    property p_rsvd_zero;
        @(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite && haddr[11:0] == dhg_pkg::HOLE_CTRL_OFS
            |=> hrdata[dhg_pkg::HOLE_EN_BIT-1:0] == 7'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

    property p_rsv_half;
        @(posedge hclk) disable iff (!hresetn)
        gmode_q == dhg_pkg::GMODE_512K
            |=> gfx_stolen_base == $past(mem_top) - dhg_pkg::RSV_512K;
    endproperty
    a_rsv_half: assert property (p_rsv_half) else $error("512KB reserve wrong");

    property p_mode_write;
        @(posedge hclk) disable iff (!hresetn)
        !lock_q && wr_pend_q && (wr_addr_q == dhg_pkg::SYSMGMT_CTRL_OFS)
            |=> gmode_q == $past(hwdata[dhg_pkg::GMODE_LSB +: 2]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode not written");

    property p_lock_set;
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_q && (wr_addr_q == dhg_pkg::SYSMGMT_CTRL_OFS) && hwdata[dhg_pkg::LOCK_BIT]
            |=> lock_q;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock bit not set");

    property p_gfx_on;
        @(posedge hclk) disable iff (!hresetn)
        gmode_q != dhg_pkg::GMODE_OFF |=> gfx_enable && gfx_clk_en && gfx_cfg_visible;
    endproperty
    a_gfx_on: assert property (p_gfx_on) else $error("enabled graphics held off");
endmodule : dhg_decode

/* design/dhg_pkg.sv */
// constants and types for the dram hole and graphics memory decode block
package dhg_pkg;
    localparam logic [11:0] HOLE_CTRL_OFS = 12'h058;
    localparam logic [11:0] SYSMGMT_CTRL_OFS = 12'h070;
    localparam logic [7:0] HOLE_CTRL_RST = 8'h00;
    localparam logic [7:0] SYSMGMT_CTRL_RST = 8'h00;
    localparam int HOLE_EN_BIT = 7;
    localparam int GMODE_LSB = 6;
    localparam int LOCK_BIT = 1;
    localparam logic [1:0] GMODE_OFF = 2'h0;
    localparam logic [1:0] GMODE_RSVD = 2'h1;
    localparam logic [1:0] GMODE_512K = 2'h2;
    localparam logic [1:0] GMODE_1M = 2'h3;
    localparam logic [31:0] RSV_NONE = 32'h0000_0000;
    localparam logic [31:0] RSV_512K = 32'h0008_0000;
    localparam logic [31:0] RSV_1M = 32'h0010_0000;
    localparam logic [31:0] HOLE_BASE = 32'h00f0_0000;
    localparam logic [31:0] HOLE_LIMIT = 32'h0100_0000;
    localparam logic [31:0] VGA_BASE = 32'h000a_0000;
    localparam logic [31:0] VGA_LIMIT = 32'h000c_0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
    typedef enum logic [1:0] {RT_DRAM, RT_GFX, RT_HUB} dhg_route_t;
endpackage : dhg_pkg

/* design/dhg_cfg_if.sv */
// configuration carried from the register bank to the cycle routers
`timescale 1ns/1ns
interface dhg_cfg_if;
    logic hole_en;
    logic gfx_en;
    logic [31:0] stolen_base;
    logic [31:0] mem_top;
    modport src (output hole_en, output gfx_en, output stolen_base, output mem_top);
    modport dst (input hole_en, input gfx_en, input stolen_base, input mem_top);
endinterface : dhg_cfg_if

/* design/dhg_range_match.sv */
// half-open address window compare
`timescale 1ns/1ns
module dhg_range_match #(
    parameter logic [31:0] BASE = 32'h0000_0000,
    parameter logic [31:0] LIMIT = 32'h0000_0000
) (
    input wire logic [31:0] addr,
    output logic hit
);
    assign hit = (addr >= BASE) && (addr < LIMIT);
endmodule : dhg_range_match

/* design/dhg_router.sv */
// steers one memory cycle to dram, internal graphics or the hub interface
`timescale 1ns/1ns
module dhg_router (
    dhg_cfg_if.dst cfg,
    input wire logic [31:0] addr,
    input wire logic smm,
    output dhg_pkg::dhg_route_t route
);
    logic in_hole;
    logic in_vga;

    dhg_range_match #(.BASE(dhg_pkg::HOLE_BASE), .LIMIT(dhg_pkg::HOLE_LIMIT)) u_hole (
        .addr(addr),
        .hit(in_hole)
    );
    dhg_range_match #(.BASE(dhg_pkg::VGA_BASE), .LIMIT(dhg_pkg::VGA_LIMIT)) u_vga (
        .addr(addr),
        .hit(in_vga)
    );

    always_comb
    begin
        if (cfg.hole_en && in_hole)
            route = dhg_pkg::RT_HUB;
        else if (in_vga && cfg.gfx_en && !smm)
            route = dhg_pkg::RT_GFX;
        else if (in_vga)
            route = dhg_pkg::RT_HUB;
        else if (addr < cfg.stolen_base)
            route = dhg_pkg::RT_DRAM;
        else if (addr < cfg.mem_top)
            route = dhg_pkg::RT_GFX;
        else
            route = dhg_pkg::RT_HUB;
    end
endmodule : dhg_router

/* tb/dhg_far_model.sv */
// far-side model: host processor bus and hub interface cycle requesters
`timescale 1ns/1ns
module dhg_far_model (
    input wire logic hclk,
    output logic host_req,
    output logic [31:0] host_addr,
    output logic host_smm,
    input wire logic host_ack,
    input wire dhg_pkg::dhg_route_t host_route,
    input wire logic [31:0] host_dram_addr,
    output logic hub_req,
    output logic [31:0] hub_addr,
    input wire logic hub_done,
    input wire logic hub_accept
);
    initial
    begin
        host_req = 1'b0;
        host_addr = 32'h0000_0000;
        host_smm = 1'b0;
        hub_req = 1'b0;
        hub_addr = 32'h0000_0000;
    end

    // one host cycle; released lines show the inverse of the last value
    task automatic host_cycle(input logic [31:0] a, input logic s, output logic ack,
                              output logic [1:0] r, output logic [31:0] da);
        @(posedge hclk);
        host_req <= 1'b1;
        host_addr <= a;
        host_smm <= s;
        @(posedge hclk);
        host_req <= 1'b0;
        host_addr <= ~a;
        host_smm <= ~s;
        @(posedge hclk);
        ack = host_ack;
        r = host_route;
        da = host_dram_addr;
    endtask : host_cycle

    // one hub interface cycle
    task automatic hub_cycle(input logic [31:0] a, output logic done, output logic acc);
        @(posedge hclk);
        hub_req <= 1'b1;
        hub_addr <= a;
        @(posedge hclk);
        hub_req <= 1'b0;
        hub_addr <= ~a;
        @(posedge hclk);
        done = hub_done;
        acc = hub_accept;
    endtask : hub_cycle
endmodule : dhg_far_model

/* tb/dram_hole_and_graphics_memory_decode_tb.sv */
// self-checking testbench for the dram hole and graphics memory decode block
`timescale 1ns/1ns
module dram_hole_and_graphics_memory_decode_tb;
    localparam logic [31:0] MEM_TOP = 32'h0200_0000;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [31:0] mem_top = MEM_TOP;
    logic host_req, host_smm, host_ack, hub_req, hub_done, hub_accept;
    logic [31:0] host_addr, host_dram_addr, hub_addr, gfx_stolen_base;
    dhg_pkg::dhg_route_t host_route;
    logic gfx_enable, gfx_cfg_visible, gfx_clk_en;
    int n_mismatch = 0;
    int num_checks = 0;

    always #20 hclk = ~hclk;
    assign hready = hreadyout;

    dhg_decode dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mem_top(mem_top),
        .host_req(host_req), .host_addr(host_addr), .host_smm(host_smm),
        .host_ack(host_ack), .host_route(host_route), .host_dram_addr(host_dram_addr),
        .hub_req(hub_req), .hub_addr(hub_addr), .hub_done(hub_done),
        .hub_accept(hub_accept), .gfx_enable(gfx_enable), .gfx_cfg_visible(gfx_cfg_visible),
        .gfx_clk_en(gfx_clk_en), .gfx_stolen_base(gfx_stolen_base));

    dhg_far_model far_u (.hclk(hclk), .host_req(host_req), .host_addr(host_addr),
        .host_smm(host_smm), .host_ack(host_ack), .host_route(host_route),
        .host_dram_addr(host_dram_addr), .hub_req(hub_req), .hub_addr(hub_addr),
        .hub_done(hub_done), .hub_accept(hub_accept));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= dhg_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0, "bus response");
    endtask : bus

    // write then read back one register
    task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp);
        logic [31:0] rd;
        bus(a, 1'b1, d, rd);
        bus(a, 1'b0, 32'h0, rd);
        chk(rd, exp, "register readback");
    endtask : wr_rd

    task automatic host(input logic [31:0] a, input logic s, input logic [1:0] exp);
        logic ack;
        logic [1:0] r;
        logic [31:0] da;
        far_u.host_cycle(a, s, ack, r, da);
        chk({31'h0, ack}, 32'h1, "host ack");
        chk({30'h0, r}, {30'h0, exp}, "host route");
        chk(da, a, "host dram address");
    endtask : host

    task automatic hub(input logic [31:0] a, input logic exp);
        logic done;
        logic acc;
        far_u.hub_cycle(a, done, acc);
        chk({31'h0, done}, 32'h1, "hub done");
        chk({31'h0, acc}, {31'h0, exp}, "hub accept");
    endtask : hub

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset

    task automatic t_hole();
        wr_rd(32'h58, 32'h0, 32'h0);
        host(32'h00f0_0010, 1'b0, dhg_pkg::RT_DRAM);
        wr_rd(32'h58, 32'hffff_ffff, 32'h80);
        host(32'h00f0_0000, 1'b0, dhg_pkg::RT_HUB);
        host(32'h00ff_ffff, 1'b1, dhg_pkg::RT_HUB);
        host(32'h00ef_ffff, 1'b0, dhg_pkg::RT_DRAM);
        host(32'h0100_0000, 1'b0, dhg_pkg::RT_DRAM);
        hub(32'h00f0_0010, 1'b0);
        hub(32'h0010_0000, 1'b1);
        wr_rd(32'h60, 32'hffff_ffff, 32'h0);
        wr_rd(32'h58, 32'h7f, 32'h0);
        hub(32'h00f0_0010, 1'b1);
    endtask : t_hole

    task automatic t_gfx();
        logic [31:0] rsv;
        logic en;
        int m;
        // the last pass turns graphics off again after the 1MB mode
        for (int i = 0; i < 5; i++)
        begin
            m = i % 4;
            en = (m != 0);
            rsv = (m == 2) ? dhg_pkg::RSV_512K : (m == 3) ? dhg_pkg::RSV_1M : dhg_pkg::RSV_NONE;
            wr_rd(32'h70, {24'h0, 2'(m), 6'h0}, {24'h0, 2'(m), 6'h0});
            host(32'h000b_0000, 1'b0, en ? dhg_pkg::RT_GFX : dhg_pkg::RT_HUB);
            host(32'h000a_0000, 1'b1, dhg_pkg::RT_HUB);
            host(MEM_TOP - 1, 1'b0, (rsv != 0) ? dhg_pkg::RT_GFX : dhg_pkg::RT_DRAM);
            host(MEM_TOP - rsv - 1, 1'b0, dhg_pkg::RT_DRAM);
            chk({31'h0, gfx_enable}, {31'h0, en}, "gfx enable");
            chk({31'h0, gfx_cfg_visible}, {31'h0, en}, "gfx config visible");
            chk({31'h0, gfx_clk_en}, {31'h0, en}, "gfx clock enable");
            chk(gfx_stolen_base, MEM_TOP - rsv, "stolen base");
        end
    endtask : t_gfx

    task automatic t_lock();
        wr_rd(32'h70, 32'h82, 32'h82);
        wr_rd(32'h70, 32'h40, 32'h82);
        host(32'h000b_0000, 1'b0, dhg_pkg::RT_GFX);
        do_reset();
        chk({31'h0, gfx_enable}, 32'h0, "gfx off after reset");
        wr_rd(32'h70, 32'h40, 32'h40);
    endtask : t_lock

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        do_reset();
        t_hole();
        t_gfx();
        t_lock();
        tally_and_finish();
    end

    // the tests need well under 1000 cycles; allow 5000
    initial
    begin
        #(40 * 5000);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : dram_hole_and_graphics_memory_decode_tb
